// ===== verilog/t16if_regs.vh
// Register map, field positions and mode codes of the timer interrupt flag block
`ifndef T16IF_REGS_VH
`define T16IF_REGS_VH

// Register byte offsets
`define T16IF_MASK1_OFS   4'h0
`define T16IF_MASK3_OFS   4'h4
`define T16IF_FLAGS1_OFS  4'h8
`define T16IF_FLAGS3_OFS  4'hc

// Field positions, shared by mask and flag registers
`define T16IF_OVF_BIT     0
`define T16IF_CMPA_BIT    1
`define T16IF_CMPB_BIT    2
`define T16IF_CAP_BIT     5
`define T16IF_USED_BITS   8'h27
`define T16IF_REG_RESET   8'h00

// Avalon answers
`define T16IF_RESP_OK     2'h0
`define T16IF_RESP_DECERR 2'h3

// Waveform mode codes
`define T16IF_WGM_NORMAL    4'h0
`define T16IF_WGM_PC8       4'h1
`define T16IF_WGM_PC9       4'h2
`define T16IF_WGM_PC10      4'h3
`define T16IF_WGM_CTC_OCRA  4'h4
`define T16IF_WGM_FAST8     4'h5
`define T16IF_WGM_FAST9     4'h6
`define T16IF_WGM_FAST10    4'h7
`define T16IF_WGM_PFC_ICR   4'h8
`define T16IF_WGM_PFC_OCRA  4'h9
`define T16IF_WGM_PC_ICR    4'ha
`define T16IF_WGM_PC_OCRA   4'hb
`define T16IF_WGM_CTC_ICR   4'hc
`define T16IF_WGM_FAST_ICR  4'he
`define T16IF_WGM_FAST_OCRA 4'hf

// Counter values
`define T16IF_CNT_MAX     16'hffff
`define T16IF_CNT_BOTTOM  16'h0000
`define T16IF_TOP8        16'h00ff
`define T16IF_TOP9        16'h01ff
`define T16IF_TOP10       16'h03ff

`endif

// ===== verilog/t16if_evt.v
// Flag set events of one 16-bit timer: capture, compare A/B, overflow
`timescale 1ns/1ps
`default_nettype none
`include "t16if_regs.vh"

module t16if_evt (
  input  wire        ref_clk_in,
  input  wire        rstn_in,
  input  wire        tick_in,
  input  wire        cnt_write_in,
  input  wire [15:0] counter_in,
  input  wire [15:0] compare_a_in,
  input  wire [15:0] compare_b_in,
  input  wire [15:0] capture_reg_in,
  input  wire [3:0]  waveform_mode_sel_in,
  input  wire        capture_pin_in,
  output reg  [7:0]  set_out
);

  reg         pin_q;
  reg         blk_q;
  reg         pend_a_q;
  reg         pend_b_q;
  reg  [7:0]  set_d;
  wire [15:0] top_w;
  wire        cap_pin_evt;

  // Capture register serves as counting top
  function icr_top;
    input [3:0] m;
    begin
      icr_top = (m == `T16IF_WGM_PFC_ICR) || (m == `T16IF_WGM_PC_ICR) ||
                (m == `T16IF_WGM_CTC_ICR) || (m == `T16IF_WGM_FAST_ICR);
    end
  endfunction

  // Top value of the count sequence
  function [15:0] top_of;
    input [3:0]  m;
    input [15:0] icr;
    input [15:0] ocra;
    begin
      case (m)
        `T16IF_WGM_PC8, `T16IF_WGM_FAST8: top_of = `T16IF_TOP8;
        `T16IF_WGM_PC9, `T16IF_WGM_FAST9: top_of = `T16IF_TOP9;
        `T16IF_WGM_PC10, `T16IF_WGM_FAST10: top_of = `T16IF_TOP10;
        `T16IF_WGM_PFC_ICR, `T16IF_WGM_PC_ICR, `T16IF_WGM_CTC_ICR, `T16IF_WGM_FAST_ICR: top_of = icr;
        `T16IF_WGM_PFC_OCRA, `T16IF_WGM_PC_OCRA, `T16IF_WGM_CTC_OCRA, `T16IF_WGM_FAST_OCRA: top_of = ocra;
        default: top_of = `T16IF_CNT_MAX;
      endcase
    end
  endfunction

  // Dual slope modes overflow at bottom
  function dual_slope;
    input [3:0] m;
    begin
      dual_slope = (m == `T16IF_WGM_PC8) || (m == `T16IF_WGM_PC9) || (m == `T16IF_WGM_PC10) ||
                   (m == `T16IF_WGM_PFC_ICR) || (m == `T16IF_WGM_PFC_OCRA) ||
                   (m == `T16IF_WGM_PC_ICR) || (m == `T16IF_WGM_PC_OCRA);
    end
  endfunction

  assign top_w       = top_of(waveform_mode_sel_in, capture_reg_in, compare_a_in);
  assign cap_pin_evt = capture_pin_in & ~pin_q;

  always @* begin
    set_d = `T16IF_REG_RESET;
    // Capture flag source depends on mode
    if (icr_top(waveform_mode_sel_in)) begin
      set_d[`T16IF_CAP_BIT] = tick_in && (counter_in == top_w);
    end else begin
      set_d[`T16IF_CAP_BIT] = cap_pin_evt;
    end
    // Match seen last timer clock sets flag now; force strobes never reach here
    set_d[`T16IF_CMPA_BIT] = tick_in && pend_a_q;
    set_d[`T16IF_CMPB_BIT] = tick_in && pend_b_q;
    // Overflow point per mode
    if ((waveform_mode_sel_in == `T16IF_WGM_NORMAL) || (waveform_mode_sel_in == `T16IF_WGM_CTC_OCRA) ||
        (waveform_mode_sel_in == `T16IF_WGM_CTC_ICR)) begin
      set_d[`T16IF_OVF_BIT] = tick_in && (counter_in == `T16IF_CNT_MAX);
    end else if (dual_slope(waveform_mode_sel_in)) begin
      set_d[`T16IF_OVF_BIT] = tick_in && (counter_in == `T16IF_CNT_BOTTOM);
    end else begin
      set_d[`T16IF_OVF_BIT] = tick_in && (counter_in == top_w);
    end
  end

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_q    <= 1'b0;
      blk_q    <= 1'b0;
      pend_a_q <= 1'b0;
      pend_b_q <= 1'b0;
      set_out  <= `T16IF_REG_RESET;
    end else begin
      pin_q   <= capture_pin_in;
      set_out <= set_d;
      // Counter write blocks match on following timer clock
      if (cnt_write_in) begin
        blk_q <= 1'b1;
      end else if (tick_in) begin
        blk_q <= 1'b0;
      end
      if (tick_in) begin
        pend_a_q <= (counter_in == compare_a_in) && !blk_q && !cnt_write_in;
        pend_b_q <= (counter_in == compare_b_in) && !blk_q && !cnt_write_in;
      end
    end
  end

endmodule // t16if_evt
`default_nettype wire

// ===== verilog/t16if_flg.v
// Sticky flags, clears and gated requests of one timer
`timescale 1ns/1ps
`default_nettype none
`include "t16if_regs.vh"

module t16if_flg (
  input  wire       ref_clk_in,
  input  wire       rstn_in,
  input  wire [7:0] set_in,
  input  wire [7:0] vec_ack_in,
  input  wire [7:0] wr_clr_in,
  input  wire [7:0] mask_in,
  input  wire       gie_in,
  output reg  [7:0] flags_out,
  output reg  [7:0] irq_out
);

  wire [7:0] flags_d;

  // Set wins over vector or software clear; zero writes keep flag
  assign flags_d = (set_in | (flags_out & ~(vec_ack_in | wr_clr_in))) & `T16IF_USED_BITS;

  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flags_out <= `T16IF_REG_RESET;
      irq_out   <= `T16IF_REG_RESET;
    end else begin
      flags_out <= flags_d;
      // Request needs flag, enable and global flag
      irq_out   <= flags_out & mask_in & {8{gie_in}} & ~vec_ack_in;
    end
  end

endmodule // t16if_flg
`default_nettype wire

// ===== verilog/t16if_top.v
// Interrupt mask and flag block for timers one and three, Avalon-MM slave
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "t16if_regs.vh"

module t16if_top (
  input  wire        ref_clk_in,
  input  wire        rstn_in,
  input  wire [3:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  output reg  [1:0]  avs_response_out,
  input  wire        gie_in,
  input  wire        t1_tick_in,
  input  wire        t1_counter_write_in,
  input  wire [15:0] t1_counter_in,
  input  wire [15:0] t1_compare_a_in,
  input  wire [15:0] t1_compare_b_in,
  input  wire [15:0] t1_capture_reg_in,
  input  wire [3:0]  t1_waveform_mode_sel_in,
  input  wire        t1_capture_pin_in,
  input  wire [7:0]  t1_vec_ack_in,
  input  wire        t3_tick_in,
  input  wire        t3_counter_write_in,
  input  wire [15:0] t3_counter_in,
  input  wire [15:0] t3_compare_a_in,
  input  wire [15:0] t3_compare_b_in,
  input  wire [15:0] t3_capture_reg_in,
  input  wire [3:0]  t3_waveform_mode_sel_in,
  input  wire        t3_capture_pin_in,
  input  wire [7:0]  t3_vec_ack_in,
  output wire [7:0]  t1_irq_req_out,
  output wire [7:0]  t3_irq_req_out
);

  reg  [7:0]  tmr1_irq_mask_q;
  reg  [7:0]  tmr3_irq_mask_q;
  reg         ack_q;
  reg  [31:0] rdata_d;
  reg  [1:0]  resp_d;
  wire        req_w;
  wire        wr_now;
  wire [7:0]  wbyte;
  wire [7:0]  t1_set;
  wire [7:0]  t3_set;
  wire [7:0]  tmr1_irq_flags;
  wire [7:0]  tmr3_irq_flags;
  wire [7:0]  t1_wr_clr;
  wire [7:0]  t3_wr_clr;

  // Address is one of the four mapped words
  function mapped;
    input [3:0] a;
    begin
      mapped = (a == `T16IF_MASK1_OFS) || (a == `T16IF_MASK3_OFS) ||
               (a == `T16IF_FLAGS1_OFS) || (a == `T16IF_FLAGS3_OFS);
    end
  endfunction

  assign req_w  = avs_read_in | avs_write_in;
  assign wr_now = avs_write_in && ack_q && avs_byteenable_in[0];
  assign wbyte  = avs_writedata_in[7:0] & `T16IF_USED_BITS;

  // Write one clears the flag bit
  assign t1_wr_clr = (wr_now && (avs_address_in == `T16IF_FLAGS1_OFS)) ? wbyte : `T16IF_REG_RESET;
  assign t3_wr_clr = (wr_now && (avs_address_in == `T16IF_FLAGS3_OFS)) ? wbyte : `T16IF_REG_RESET;

  t16if_evt u_t1_evt (
    .ref_clk_in           (ref_clk_in),
    .rstn_in              (rstn_in),
    .tick_in              (t1_tick_in),
    .cnt_write_in         (t1_counter_write_in),
    .counter_in           (t1_counter_in),
    .compare_a_in         (t1_compare_a_in),
    .compare_b_in         (t1_compare_b_in),
    .capture_reg_in       (t1_capture_reg_in),
    .waveform_mode_sel_in (t1_waveform_mode_sel_in),
    .capture_pin_in       (t1_capture_pin_in),
    .set_out              (t1_set)
  );

  t16if_evt u_t3_evt (
    .ref_clk_in           (ref_clk_in),
    .rstn_in              (rstn_in),
    .tick_in              (t3_tick_in),
    .cnt_write_in         (t3_counter_write_in),
    .counter_in           (t3_counter_in),
    .compare_a_in         (t3_compare_a_in),
    .compare_b_in         (t3_compare_b_in),
    .capture_reg_in       (t3_capture_reg_in),
    .waveform_mode_sel_in (t3_waveform_mode_sel_in),
    .capture_pin_in       (t3_capture_pin_in),
    .set_out              (t3_set)
  );

  t16if_flg u_t1_flg (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .set_in     (t1_set),
    .vec_ack_in (t1_vec_ack_in),
    .wr_clr_in  (t1_wr_clr),
    .mask_in    (tmr1_irq_mask_q),
    .gie_in     (gie_in),
    .flags_out  (tmr1_irq_flags),
    .irq_out    (t1_irq_req_out)
  );

  t16if_flg u_t3_flg (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .set_in     (t3_set),
    .vec_ack_in (t3_vec_ack_in),
    .wr_clr_in  (t3_wr_clr),
    .mask_in    (tmr3_irq_mask_q),
    .gie_in     (gie_in),
    .flags_out  (tmr3_irq_flags),
    .irq_out    (t3_irq_req_out)
  );

  // Read mux, reserved bits zero
  always @* begin
    rdata_d = 32'h00000000;
    resp_d  = mapped(avs_address_in) ? `T16IF_RESP_OK : `T16IF_RESP_DECERR;
    case (avs_address_in)
      `T16IF_MASK1_OFS:  rdata_d[7:0] = tmr1_irq_mask_q;
      `T16IF_MASK3_OFS:  rdata_d[7:0] = tmr3_irq_mask_q;
      `T16IF_FLAGS1_OFS: rdata_d[7:0] = tmr1_irq_flags;
      `T16IF_FLAGS3_OFS: rdata_d[7:0] = tmr3_irq_flags;
      default:           rdata_d      = 32'h00000000;
    endcase
  end

  // One wait cycle, then answer
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_q               <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h00000000;
      avs_response_out    <= `T16IF_RESP_OK;
    end else begin
      ack_q               <= req_w && !ack_q;
      avs_waitrequest_out <= !(req_w && !ack_q);
      if (req_w && !ack_q) begin
        avs_readdata_out <= avs_read_in ? rdata_d : 32'h00000000;
        avs_response_out <= resp_d;
      end
    end
  end

  // Mask registers: capture 5, cmpB 2, cmpA 1, ovf 0
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tmr1_irq_mask_q <= `T16IF_REG_RESET;
      tmr3_irq_mask_q <= `T16IF_REG_RESET;
    end else if (wr_now) begin
      if (avs_address_in == `T16IF_MASK1_OFS) begin
        tmr1_irq_mask_q <= wbyte;
      end
      if (avs_address_in == `T16IF_MASK3_OFS) begin
        tmr3_irq_mask_q <= wbyte;
      end
    end
  end

endmodule // t16if_top
`default_nettype wire

// ===== test/t16if_asserts.sv
// Port assertions of the timer interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module t16if_chk (
  input wire logic        ref_clk_in,
  input wire logic        rstn_in,
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic [1:0]  avs_response_out,
  input wire logic        gie_in,
  input wire logic [7:0]  t1_vec_ack_in,
  input wire logic [7:0]  t3_vec_ack_in,
  input wire logic [7:0]  t1_irq_req_out,
  input wire logic [7:0]  t3_irq_req_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  wire logic req = avs_read_in || avs_write_in;
  wire logic ans = req && !avs_waitrequest_out;
  wire logic [7:0] irq_all = t1_irq_req_out | t3_irq_req_out;
  chk_gie_off: assert property (!gie_in |=> irq_all == 8'h00)
    else $error("request seen without global enable");
  chk_irq_unused: assert property ((irq_all & 8'hd8) == 8'h00)
    else $error("request on unused bit");
  chk_rd_unused: assert property (ans && avs_read_in |-> (avs_readdata_out & 32'hffffffd8) == 32'h0)
    else $error("unused read bits not zero");
  chk_one_wait: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("answer not one cycle after request");
  chk_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  chk_decode_err: assert property (ans && avs_address_in[1:0] != 2'h0 |-> avs_response_out == 2'h3)
    else $error("unmapped access not refused");
  chk_resp_ok: assert property (ans && avs_address_in[1:0] == 2'h0 |-> avs_response_out == 2'h0)
    else $error("mapped access refused");
  chk_vec_clear: assert property ((t1_vec_ack_in | t3_vec_ack_in) != 8'h00 |=>
    ((t1_irq_req_out & $past(t1_vec_ack_in)) | (t3_irq_req_out & $past(t3_vec_ack_in))) == 8'h00)
    else $error("request kept after vector ran");
endmodule // t16if_chk
bind t16if_top t16if_chk i_chk (
  .ref_clk_in          (ref_clk_in),
  .rstn_in             (rstn_in),
  .avs_address_in      (avs_address_in),
  .avs_read_in         (avs_read_in),
  .avs_write_in        (avs_write_in),
  .avs_readdata_out    (avs_readdata_out),
  .avs_waitrequest_out (avs_waitrequest_out),
  .avs_response_out    (avs_response_out),
  .gie_in              (gie_in),
  .t1_vec_ack_in       (t1_vec_ack_in),
  .t3_vec_ack_in       (t3_vec_ack_in),
  .t1_irq_req_out      (t1_irq_req_out),
  .t3_irq_req_out      (t3_irq_req_out)
);
`default_nettype wire

// ===== test/t16if_cpu_model.sv
// CPU vector logic model: runs the lowest pending vector after a latency
`timescale 1ns/1ps
`default_nettype none
module t16if_cpu_model #(
  parameter int LAT = 2
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       ack_en_in,
  input  wire logic [7:0] irq_req_in,
  output var  logic [7:0] vec_ack_out
);
  int wait_q;
  always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_q      <= 0;
      vec_ack_out <= 8'h00;
    end else if (vec_ack_out != 8'h00 || !ack_en_in || irq_req_in == 8'h00) begin
      wait_q      <= 0;
      vec_ack_out <= 8'h00;
    end else if (wait_q >= LAT) begin
      wait_q      <= 0;
      vec_ack_out <= irq_req_in & (~irq_req_in + 8'h01);
    end else begin
      wait_q <= wait_q + 1;
    end
  end
endmodule // t16if_cpu_model
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench of the timer interrupt flag block
`timescale 1ns/1ps
`default_nettype none
`include "t16if_regs.vh"
module tb_top;
  logic        ref_clk_in = 1'b0;
  logic        rstn_in    = 1'b0;
  logic [3:0]  addr       = 4'h0;
  logic        rd         = 1'b0;
  logic        wr         = 1'b0;
  logic        gie        = 1'b0;
  logic [31:0] wdata      = 32'h0;
  logic [31:0] rdata;
  logic        waitreq;
  logic        tick[2], cw[2], pin[2], ack_en[2];
  logic [15:0] cnt[2], cmpa[2], cmpb[2], icr[2];
  logic [3:0]  mode[2];
  logic [7:0]  ack[2], irq[2];
  logic [7:0]  exp_q[$];
  logic [7:0]  m;
  logic [3:0]  ma, fa;
  int          error_cnt = 0;
  int          check_count = 0;
  int          cyc = 0;
  always #2 ref_clk_in = ~ref_clk_in;
  t16if_top i_dut (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .avs_response_out(), .gie_in(gie),
    .t1_tick_in(tick[0]), .t1_counter_write_in(cw[0]), .t1_counter_in(cnt[0]), .t1_compare_a_in(cmpa[0]),
    .t1_compare_b_in(cmpb[0]), .t1_capture_reg_in(icr[0]), .t1_waveform_mode_sel_in(mode[0]),
    .t1_capture_pin_in(pin[0]), .t1_vec_ack_in(ack[0]), .t1_irq_req_out(irq[0]),
    .t3_tick_in(tick[1]), .t3_counter_write_in(cw[1]), .t3_counter_in(cnt[1]), .t3_compare_a_in(cmpa[1]),
    .t3_compare_b_in(cmpb[1]), .t3_capture_reg_in(icr[1]), .t3_waveform_mode_sel_in(mode[1]),
    .t3_capture_pin_in(pin[1]), .t3_vec_ack_in(ack[1]), .t3_irq_req_out(irq[1]));
  t16if_cpu_model #(.LAT(0)) i_cpu1 (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ack_en_in(ack_en[0]),
    .irq_req_in(irq[0]), .vec_ack_out(ack[0]));
  t16if_cpu_model #(.LAT(5)) i_cpu3 (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ack_en_in(ack_en[1]),
    .irq_req_in(irq[1]), .vec_ack_out(ack[1]));
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    if (exp_q.size() != 0) error_cnt++;
    $display("checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bus(logic w, logic [3:0] a, logic [7:0] d);
    @(posedge ref_clk_in);
    if (!w) exp_q.push_back(d);
    addr  <= a;
    rd    <= !w;
    wr    <= w;
    wdata <= {24'h000000, d};
    do @(posedge ref_clk_in); while (waitreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic ticks(int t, int n);
    repeat (n) begin
      tick[t] <= 1'b1;
      @(posedge ref_clk_in);
      tick[t] <= 1'b0;
      @(posedge ref_clk_in);
    end
  endtask
  // Read answers checked against the oldest note
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (rd && waitreq === 1'b0 && exp_q.size() > 0) chk("read data", exp_q.pop_front(), rdata[7:0]);
    if (cyc == 6000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    for (int t = 0; t < 2; t++) begin
      {tick[t], cw[t], pin[t], ack_en[t]} = 4'h0;
      cnt[t]  = 16'h0000;
      cmpa[t] = 16'h1234;
      cmpb[t] = 16'h5678;
      icr[t]  = 16'h0200;
      mode[t] = `T16IF_WGM_NORMAL;
    end
    repeat (2) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    void'($urandom(32'hf25a2338));
    for (int a = 0; a < 16; a += 2) bus(0, a[3:0], 8'h00);
    for (int t = 0; t < 2; t++) begin
      ma = t ? `T16IF_MASK3_OFS : `T16IF_MASK1_OFS;
      fa = t ? `T16IF_FLAGS3_OFS : `T16IF_FLAGS1_OFS;
      m  = $urandom;
      bus(1, ma, m);
      bus(0, ma, m & 8'h27);
      bus(1, ma, 8'hff);
      bus(0, ma, 8'h27);
      cnt[t] <= cmpa[t];
      ticks(t, 1);
      cnt[t] <= 16'h0001;
      bus(0, fa, 8'h00);
      ticks(t, 1);
      bus(0, fa, 8'h02);
      cw[t] <= 1'b1;
      @(posedge ref_clk_in);
      cw[t]  <= 1'b0;
      cnt[t] <= cmpb[t];
      ticks(t, 1);
      cnt[t] <= 16'h0001;
      ticks(t, 1);
      bus(0, fa, 8'h02);
      cnt[t] <= cmpb[t];
      ticks(t, 1);
      cnt[t] <= 16'h0001;
      ticks(t, 1);
      bus(0, fa, 8'h06);
      pin[t] <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      bus(0, fa, 8'h26);
      cnt[t] <= `T16IF_CNT_MAX;
      ticks(t, 1);
      cnt[t] <= 16'h0001;
      bus(0, fa, 8'h27);
      bus(1, fa, 8'h00);
      bus(0, fa, 8'h27);
      bus(1, fa, 8'h02);
      bus(0, fa, 8'h25);
      gie <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      chk("irq request", 8'h25, irq[t]);
      ack_en[t] <= 1'b1;
      repeat (40) @(posedge ref_clk_in);
      chk("irq request", 8'h00, irq[t]);
      bus(0, fa, 8'h00);
      ack_en[t] <= 1'b0;
      gie       <= 1'b0;
      pin[t]    <= 1'b0;
      mode[t]   <= `T16IF_WGM_CTC_ICR;
      cnt[t]    <= icr[t];
      ticks(t, 1);
      cnt[t] <= 16'h0001;
      bus(0, fa, 8'h20);
      bus(1, fa, 8'h27);
      mode[t] <= `T16IF_WGM_PC8;
      cnt[t]  <= `T16IF_CNT_BOTTOM;
      ticks(t, 1);
      bus(0, fa, 8'h01);
      bus(1, fa, 8'h01);
      mode[t] <= `T16IF_WGM_FAST10;
      cnt[t]  <= `T16IF_TOP10;
      ticks(t, 1);
      bus(0, fa, 8'h01);
      cnt[t]  <= 16'h0001;
      mode[t] <= `T16IF_WGM_NORMAL;
    end
    repeat (4) @(posedge ref_clk_in);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
